/* rtl/bcu_params.svh */
// Constants for the bounds check unit: field positions, reset values, codes.
// Included by the package and the design modules; definitions only.
`ifndef BCU_PARAMS_SVH
`define BCU_PARAMS_SVH
`define BCU_ADDR_W 64
`define BCU_NUM_BREGS 4
`define BCU_BREG_IDX_W 3
`define BCU_FEATURE_BIT 14
`define BCU_CFG_EN_BIT 0
`define BCU_CFG_PRESERVE_BIT 1
`define BCU_CFG_RSVD_LO 2
`define BCU_CFG_RSVD_HI 11
`define BCU_VA_BITS 48
`define BCU_EC_NONE 2'h0
`define BCU_EC_BOUNDS 2'h1
`define BCU_EC_BD_INVALID 2'h2
`define BCU_CFG_RESET 64'h0000000000000000
`define BCU_STATUS_RESET 64'h0000000000000000
`define BCU_BOUND_RESET 64'h0000000000000000
`endif

/* rtl/bcu_pkg.sv */
// Types shared by the bounds check unit and its leaf modules.
// Assumes bcu_params.svh is on the include path.
`include "bcu_params.svh"
package bcu_pkg;
  typedef enum logic [3:0] {
    BCU_OP_NONE,
    BCU_OP_MAKE,
    BCU_OP_CHK_LO,
    BCU_OP_CHK_UP_CPL,
    BCU_OP_CHK_UP_PLAIN,
    BCU_OP_MOV_LOAD,
    BCU_OP_MOV_STORE,
    BCU_OP_TLOAD,
    BCU_OP_TSTORE,
    BCU_OP_CFG_RD,
    BCU_OP_CFG_WR,
    BCU_OP_STATE_SAVE
  } bcu_op_t;

  typedef struct packed {
    logic [`BCU_ADDR_W-1:0] lower_bound;
    logic [`BCU_ADDR_W-1:0] upper_bound;
  } bcu_bound_t;

  typedef struct packed {
    bcu_op_t op;
    logic [`BCU_BREG_IDX_W-1:0] dst_idx;
    logic [`BCU_BREG_IDX_W-1:0] src_idx;
    logic src_is_mem;
    logic dst_is_mem;
    logic [`BCU_ADDR_W-1:0] base_addr;
    logic [`BCU_ADDR_W-1:0] eff_addr;
    logic [`BCU_ADDR_W-1:0] index_val;
    logic prefix_66;
    logic prefix_wide;
    logic mode_64;
  } bcu_req_t;

  typedef struct packed {
    bcu_bound_t bounds;
    logic [`BCU_ADDR_W-1:0] pointer_val;
  } bcu_entry_t;
endpackage : bcu_pkg

/* rtl/bcu_canon_check.sv */
// Canonical-form and reserved-bit check of a configuration write value.
// Purely combinational; the caller samples the result in the write cycle.
`timescale 1ns/10ps
`include "bcu_params.svh"
module bcu_canon_check #(
  parameter int VA_BITS = `BCU_VA_BITS
) (
  // Value under test
  input wire logic [63:0] value_i,
  // Result
  output logic ok_o
);
  import bcu_pkg::*;
  logic [63:0] upper;
  logic canon;
  logic rsvd_zero;
  assign upper = value_i >> (VA_BITS - 1);
  // Checked independent of mode, on all 64 bits
  assign canon = (upper == 64'h0) || (upper == ({64{1'b1}} >> (VA_BITS - 1)));
  assign rsvd_zero = (value_i[`BCU_CFG_RSVD_HI:`BCU_CFG_RSVD_LO] == 10'h000);
  assign ok_o = canon && rsvd_zero;
endmodule : bcu_canon_check

/* rtl/bcu_bound_compare.sv */
// One bound comparator: unsigned, inclusive, optional one's complement of the stored bound.
// Instantiated once for the lower and once for the upper limit.
`timescale 1ns/10ps
`include "bcu_params.svh"
module bcu_bound_compare #(
  parameter int W = `BCU_ADDR_W,
  parameter bit IS_UPPER = 1'b0
) (
  // Operands
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] bound_i,
  input wire logic complement_i,
  // Result
  output logic fail_o
);
  import bcu_pkg::*;
  logic [W-1:0] limit;
  // With complement_i set, a stored upper bound of zero decodes to all ones, covering the whole space
  assign limit = complement_i ? ~bound_i : bound_i;
  generate
    if (IS_UPPER) begin : g_up
      assign fail_o = addr_i > limit;
    end else begin : g_lo
      assign fail_o = addr_i < limit;
    end
  endgenerate
endmodule : bcu_bound_compare

/* rtl/bcu_unit.sv */
// Bounds check unit: bounds registers, check/make/move/translate ops, config register.
// Assumes the pipeline issues one request per valid cycle and handles faults it reports.
`timescale 1ns/10ps
`include "bcu_params.svh"
module bcu_unit #(
  parameter int NUM_BREGS = `BCU_NUM_BREGS,
  parameter bit FEATURE_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic init_i,
  // Request from the pipeline
  input wire logic req_valid_i,
  input wire bcu_pkg::bcu_req_t req_i,
  input wire logic os_enable_i,
  input wire logic user_mode_i,
  input wire logic [63:0] user_config_i,
  // Memory operand and translated entry read data, config write data
  input wire bcu_pkg::bcu_bound_t mem_bounds_i,
  input wire bcu_pkg::bcu_entry_t entry_i,
  input wire logic [63:0] cfg_wdata_i,
  // Feature enumeration
  output logic [31:0] feature_bits_o,
  // Completion
  output logic done_o,
  output logic nop_o,
  output logic bound_range_fault_o,
  output logic undefined_opcode_fault_o,
  output logic general_protection_fault_o,
  // Writes toward memory
  output logic mem_wr_o,
  output bcu_pkg::bcu_bound_t mem_wbounds_o,
  output logic entry_wr_o,
  output bcu_pkg::bcu_entry_t entry_wdata_o,
  output logic [63:0] entry_lookup_addr_o,
  // Register results
  output logic [63:0] cfg_rdata_o,
  output logic [63:0] bounds_fault_status_o,
  output bcu_pkg::bcu_bound_t bound_rd_o
);
  import bcu_pkg::*;

  bcu_bound_t bounds_reg [NUM_BREGS];
  logic [63:0] supervisor_bounds_config_reg;
  logic [63:0] status_reg;
  logic [63:0] status_next;
  // Kept for the neighbouring pointer compare; no port carries it yet
  logic [63:0] load_entry_ptr_reg;
  logic enabled;
  logic is_bnd_op;
  logic idx_bad;
  logic xlat_ok;
  logic exec;
  logic is_check;
  logic chk_fail;
  logic lo_fail;
  logic up_fail;
  logic canon_ok;
  logic [1:0] src_sel;
  logic [1:0] dst_sel;
  logic [63:0] eff;
  logic [63:0] base;
  logic [63:0] idx_val;
  bcu_bound_t src_b;
  logic [63:0] cfg_en_src;

  assign feature_bits_o = FEATURE_PRESENT ? (32'h1 << `BCU_FEATURE_BIT) : 32'h0;

  always_comb begin
    cfg_en_src = user_mode_i ? user_config_i : supervisor_bounds_config_reg;
  end

  assign enabled = FEATURE_PRESENT && os_enable_i && cfg_en_src[`BCU_CFG_EN_BIT];

  always_comb begin
    unique case (req_i.op)
      BCU_OP_MAKE, BCU_OP_CHK_LO, BCU_OP_CHK_UP_CPL, BCU_OP_CHK_UP_PLAIN,
      BCU_OP_MOV_LOAD, BCU_OP_MOV_STORE, BCU_OP_TLOAD, BCU_OP_TSTORE: is_bnd_op = 1'b1;
      default: is_bnd_op = 1'b0;
    endcase
  end

  assign is_check = (req_i.op == BCU_OP_CHK_LO) || (req_i.op == BCU_OP_CHK_UP_CPL) ||
                    (req_i.op == BCU_OP_CHK_UP_PLAIN);

  // Register operands outside 0..3 are illegal, memory operands are not checked
  assign idx_bad = (req_i.dst_idx > 3'h3 && !req_i.dst_is_mem) ||
                   (req_i.src_idx > 3'h3 && !req_i.src_is_mem);

  // Translated forms without the mandatory prefix decode as undefined
  assign xlat_ok = !((req_i.op == BCU_OP_TLOAD || req_i.op == BCU_OP_TSTORE) &&
                     !req_i.prefix_66);

  assign exec = req_valid_i && is_bnd_op && enabled && !idx_bad && xlat_ok;
  assign src_sel = req_i.src_idx[1:0];
  assign dst_sel = req_i.dst_idx[1:0];

  // Operand width follows the address mode; the wide prefix and 66H do not widen it
  always_comb begin
    eff = req_i.mode_64 ? req_i.eff_addr : {32'h0, req_i.eff_addr[31:0]};
    base = req_i.mode_64 ? req_i.base_addr : {32'h0, req_i.base_addr[31:0]};
    idx_val = req_i.mode_64 ? req_i.index_val : {32'h0, req_i.index_val[31:0]};
  end

  always_comb begin
    src_b = req_i.src_is_mem ? mem_bounds_i : bounds_reg[src_sel];
  end

  // Address to check is supplied by the pipeline; upper checks expect size minus one added
  bcu_bound_compare #(.W(64), .IS_UPPER(1'b0)) u_cmp_lo (
    .addr_i(eff),
    .bound_i(bounds_reg[dst_sel].lower_bound),
    .complement_i(1'b0),
    .fail_o(lo_fail)
  );

  bcu_bound_compare #(.W(64), .IS_UPPER(1'b1)) u_cmp_up (
    .addr_i(eff),
    .bound_i(bounds_reg[dst_sel].upper_bound),
    .complement_i(req_i.op == BCU_OP_CHK_UP_CPL),
    .fail_o(up_fail)
  );

  always_comb begin
    unique case (req_i.op)
      BCU_OP_CHK_LO: chk_fail = lo_fail;
      BCU_OP_CHK_UP_CPL, BCU_OP_CHK_UP_PLAIN: chk_fail = up_fail;
      default: chk_fail = 1'b0;
    endcase
  end

  bcu_canon_check #(.VA_BITS(`BCU_VA_BITS)) u_canon (
    .value_i(cfg_wdata_i),
    .ok_o(canon_ok)
  );

  // Bounds registers; init_i clears them, otherwise a write needs an enabled, legal op, so no-ops leave them alone
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NUM_BREGS; i++) begin
        bounds_reg[i] <= {`BCU_BOUND_RESET, `BCU_BOUND_RESET};
      end
    end else if (init_i) begin
      for (int i = 0; i < NUM_BREGS; i++) begin
        bounds_reg[i] <= {`BCU_BOUND_RESET, `BCU_BOUND_RESET};
      end
    end else if (exec) begin
      unique case (req_i.op)
        BCU_OP_MAKE: begin
          bounds_reg[dst_sel].lower_bound <= base;
          bounds_reg[dst_sel].upper_bound <= ~eff;
        end
        BCU_OP_MOV_LOAD: begin
          bounds_reg[dst_sel] <= src_b;
        end
        BCU_OP_MOV_STORE: begin
          if (!req_i.dst_is_mem) begin
            bounds_reg[dst_sel] <= bounds_reg[src_sel];
          end
        end
        BCU_OP_TLOAD: begin
          bounds_reg[dst_sel] <= entry_i.bounds;
        end
        default: begin
        end
      endcase
    end
  end

  // Pointer value loaded by the translated load, held internally; no port carries it to the pipeline
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_entry_ptr_reg <= 64'h0;
    end else if (exec && req_i.op == BCU_OP_TLOAD) begin
      load_entry_ptr_reg <= entry_i.pointer_val;
    end
  end

  // Config register: only the register read/write ops touch it, state save does not
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      supervisor_bounds_config_reg <= `BCU_CFG_RESET;
    end else if (init_i) begin
      supervisor_bounds_config_reg <= `BCU_CFG_RESET;
    end else if (req_valid_i && req_i.op == BCU_OP_CFG_WR && FEATURE_PRESENT && canon_ok) begin
      supervisor_bounds_config_reg <= cfg_wdata_i;
    end
  end

  always_comb begin
    status_next = status_reg;
    if (exec && is_check && chk_fail) begin
      status_next = {62'h0, `BCU_EC_BOUNDS};
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_reg <= `BCU_STATUS_RESET;
    end else if (init_i) begin
      status_reg <= `BCU_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Completion outputs, registered one cycle after the request
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_o <= 1'b0;
      nop_o <= 1'b0;
    end else begin
      done_o <= req_valid_i;
      nop_o <= req_valid_i && is_bnd_op && !enabled;
    end
  end

  // Fault pulses; the causes exclude one another for any single request
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bound_range_fault_o <= 1'b0;
      undefined_opcode_fault_o <= 1'b0;
      general_protection_fault_o <= 1'b0;
    end else begin
      bound_range_fault_o <= exec && is_check && chk_fail;
      undefined_opcode_fault_o <= req_valid_i && is_bnd_op && enabled &&
                                  (idx_bad || !xlat_ok);
      general_protection_fault_o <= req_valid_i &&
        (((req_i.op == BCU_OP_CFG_WR || req_i.op == BCU_OP_CFG_RD) && !FEATURE_PRESENT) ||
         (req_i.op == BCU_OP_CFG_WR && FEATURE_PRESENT && !canon_ok));
    end
  end

  // Memory side writes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_wr_o <= 1'b0;
      mem_wbounds_o <= '0;
    end else begin
      mem_wr_o <= exec && req_i.op == BCU_OP_MOV_STORE && req_i.dst_is_mem;
      mem_wbounds_o <= bounds_reg[src_sel];
    end
  end

  // Translated store toward the bound table entry
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      entry_wr_o <= 1'b0;
      entry_wdata_o <= '0;
      entry_lookup_addr_o <= 64'h0;
    end else begin
      entry_wr_o <= exec && req_i.op == BCU_OP_TSTORE;
      entry_wdata_o <= {bounds_reg[src_sel], idx_val};
      entry_lookup_addr_o <= base;
    end
  end

  // Config read data holds until the next config read
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_rdata_o <= 64'h0;
    end else if (req_valid_i && req_i.op == BCU_OP_CFG_RD && FEATURE_PRESENT) begin
      cfg_rdata_o <= supervisor_bounds_config_reg;
    end
  end

  // Bounds read-back; the register write lands with this same edge,
  // so a translated load shows the fetched entry instead of the old register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bound_rd_o <= '0;
    end else if (req_valid_i && req_i.op == BCU_OP_TLOAD) begin
      bound_rd_o <= entry_i.bounds;
    end else begin
      bound_rd_o <= bounds_reg[dst_sel];
    end
  end

  assign bounds_fault_status_o = status_reg;
endmodule : bcu_unit

/* dv/bcu_unit_chk.sv */
// Port-level checker for bcu_unit: completion, fault causes and side effects.
// Bound to every bcu_unit instance; sees its ports only.
`timescale 1ns/10ps
module bcu_unit_chk import bcu_pkg::*; #(
  parameter bit FEATURE_PRESENT = 1'b1
) (
  // Clock, reset and request
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire bcu_pkg::bcu_req_t req_i,
  input wire logic os_enable_i,
  input wire logic [63:0] cfg_wdata_i,
  // Results
  input wire logic [31:0] feature_bits_o,
  input wire logic done_o,
  input wire logic nop_o,
  input wire logic bound_range_fault_o,
  input wire logic undefined_opcode_fault_o,
  input wire logic general_protection_fault_o,
  input wire logic mem_wr_o,
  input wire logic entry_wr_o,
  input wire bcu_pkg::bcu_entry_t entry_wdata_o,
  input wire logic [63:0] entry_lookup_addr_o,
  input wire logic [63:0] bounds_fault_status_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_done; req_valid_i |=> done_o; endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_done_cause; done_o |-> $past(req_valid_i); endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without request");
  property p_brf_op;
    bound_range_fault_o |-> $past(req_i.op) inside {BCU_OP_CHK_LO, BCU_OP_CHK_UP_CPL,
      BCU_OP_CHK_UP_PLAIN};
  endproperty
  a_brf_op: assert property (p_brf_op) else $error("range fault from non-check");
  property p_status; bound_range_fault_o |-> bounds_fault_status_o == 64'h1; endproperty
  a_status: assert property (p_status) else $error("status code wrong");
  property p_feature; feature_bits_o[14] == FEATURE_PRESENT; endproperty
  a_feature: assert property (p_feature) else $error("feature bit wrong");
  property p_off_nop;
    req_valid_i && !os_enable_i && req_i.op inside {[BCU_OP_MAKE:BCU_OP_TSTORE]} |=> nop_o;
  endproperty
  a_off_nop: assert property (p_off_nop) else $error("disabled op not a no-op");
  property p_nop_quiet;
    nop_o |-> !(bound_range_fault_o || undefined_opcode_fault_o || mem_wr_o || entry_wr_o);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-op had effects");
  property p_idx;
    req_valid_i && req_i.op == BCU_OP_MOV_LOAD && !req_i.src_is_mem && !req_i.dst_is_mem
      && (req_i.dst_idx > 3'h3 || req_i.src_idx > 3'h3) |=> undefined_opcode_fault_o || nop_o;
  endproperty
  a_idx: assert property (p_idx) else $error("bad index not refused");
  property p_canon;
    req_valid_i && req_i.op == BCU_OP_CFG_WR && cfg_wdata_i[63:47] != 17'h0
      && cfg_wdata_i[63:47] != 17'h1FFFF |=> general_protection_fault_o;
  endproperty
  a_canon: assert property (p_canon) else $error("noncanonical write accepted");
  property p_tstore;
    entry_wr_o |-> entry_lookup_addr_o == ($past(req_i.mode_64) ? $past(req_i.base_addr)
      : {32'h0, $past(req_i.base_addr[31:0])})
      && entry_wdata_o.pointer_val == ($past(req_i.mode_64) ? $past(req_i.index_val)
      : {32'h0, $past(req_i.index_val[31:0])});
  endproperty
  a_tstore: assert property (p_tstore) else $error("entry write wrong");
endmodule : bcu_unit_chk

bind bcu_unit bcu_unit_chk #(.FEATURE_PRESENT(FEATURE_PRESENT)) u_chk (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .os_enable_i(os_enable_i), .cfg_wdata_i(cfg_wdata_i), .feature_bits_o(feature_bits_o),
  .done_o(done_o), .nop_o(nop_o), .bound_range_fault_o(bound_range_fault_o),
  .undefined_opcode_fault_o(undefined_opcode_fault_o),
  .general_protection_fault_o(general_protection_fault_o), .mem_wr_o(mem_wr_o),
  .entry_wr_o(entry_wr_o), .entry_wdata_o(entry_wdata_o),
  .entry_lookup_addr_o(entry_lookup_addr_o), .bounds_fault_status_o(bounds_fault_status_o)
);

/* dv/bcu_pipe_model.sv */
// Pipeline model: issues one bounds request per call, one cycle wide.
// Drives on the falling edge; the unit takes it at the next rising edge.
`timescale 1ns/10ps
module bcu_pipe_model import bcu_pkg::*; (
  // Clock and mode
  input wire logic clk_sys_i,
  input wire logic mode_64_i,
  // Request toward the unit
  output logic req_valid_o,
  output bcu_pkg::bcu_req_t req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  task automatic issue(input bcu_op_t op, input logic [2:0] d, input logic [2:0] s,
                       input logic m, input logic [63:0] b, input logic [63:0] e,
                       input logic [63:0] x, input logic p66);
    @(negedge clk_sys_i);
    // Wide prefix always set: the unit must ignore it
    req_o <= '{op, d, s, m, m, b, e, x, p66, 1'b1, mode_64_i};
    req_valid_o <= 1'b1;
    @(negedge clk_sys_i);
    // Idle fields scramble so nothing leans on a stale value
    req_o <= bcu_req_t'(~req_o);
    req_valid_o <= 1'b0;
  endtask : issue
endmodule : bcu_pipe_model

/* dv/tb_top.sv */
// Self-checking bench for bcu_unit, requests issued through the pipeline model.
// Assumes the checker file binds itself to the unit.
`timescale 1ns/10ps
module tb_top;
  import bcu_pkg::*;
  localparam logic [63:0] B = 64'h1000;
  localparam logic [63:0] E = 64'h10FF;
  localparam logic [63:0] P = 64'hABC0;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic init_i = 1'b0;
  logic os_en = 1'b1;
  logic mode_64 = 1'b1;
  logic mem = 1'b1;
  logic p66 = 1'b1;
  logic req_valid;
  bcu_req_t req;
  bcu_bound_t mem_bounds = '{64'h2000, 64'h3000};
  bcu_entry_t entry = '{'{64'h4000, 64'h5000}, 64'h6000};
  logic [63:0] cfg_wdata = 64'h0;
  logic [31:0] feat;
  logic done, nop, brf, udf, gpf, mem_wr, entry_wr;
  bcu_bound_t mem_wb, bound_rd;
  bcu_entry_t entry_wd;
  logic [63:0] lookup, cfg_rd, status;
  int n_mismatch = 0;
  int tests_run = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  bcu_pipe_model pipe (.clk_sys_i(clk_sys_i), .mode_64_i(mode_64), .req_valid_o(req_valid),
    .req_o(req));
  bcu_unit uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .init_i(init_i),
    .req_valid_i(req_valid), .req_i(req), .os_enable_i(os_en), .user_mode_i(1'b0),
    .user_config_i(64'h0), .mem_bounds_i(mem_bounds), .entry_i(entry), .cfg_wdata_i(cfg_wdata),
    .feature_bits_o(feat), .done_o(done), .nop_o(nop), .bound_range_fault_o(brf),
    .undefined_opcode_fault_o(udf), .general_protection_fault_o(gpf), .mem_wr_o(mem_wr),
    .mem_wbounds_o(mem_wb), .entry_wr_o(entry_wr), .entry_wdata_o(entry_wd),
    .entry_lookup_addr_o(lookup), .cfg_rdata_o(cfg_rd), .bounds_fault_status_o(status),
    .bound_rd_o(bound_rd));

  task automatic chk(input logic [319:0] got, input logic [319:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic fl(input logic [3:0] exp);
    chk({done, nop, brf, udf, gpf}, {1'b1, exp});
  endtask : fl
  task automatic op(input bcu_op_t o, input logic [2:0] d, input logic [2:0] s,
                    input logic [63:0] e);
    pipe.issue(o, d, s, mem, B, e, P, p66);
  endtask : op
  task automatic t_cfg;
    chk(feat, 32'h00004000);
    op(BCU_OP_MAKE, 3'h1, 3'h1, E);
    fl(4'b1000);
    mode_64 = 1'b0;
    cfg_wdata = 64'h0000800000000001;
    op(BCU_OP_CFG_WR, 3'h0, 3'h0, E);
    fl(4'b0001);
    mode_64 = 1'b1;
    cfg_wdata = 64'h0000000000000005;
    op(BCU_OP_CFG_WR, 3'h0, 3'h0, E);
    fl(4'b0001);
    os_en = 1'b0;
    cfg_wdata = 64'h1;
    op(BCU_OP_CFG_WR, 3'h0, 3'h0, E);
    fl(4'b0000);
    cfg_wdata = 64'h0000000000001000;
    op(BCU_OP_STATE_SAVE, 3'h0, 3'h0, E);
    fl(4'b0000);
    op(BCU_OP_CFG_RD, 3'h0, 3'h0, E);
    chk(cfg_rd, 64'h1);
    cfg_wdata = 64'h1;
    os_en = 1'b1;
  endtask : t_cfg
  task automatic t_zero;
    for (int k = 0; k < 4; k++) begin
      op(BCU_OP_MOV_STORE, 3'h0, 3'(k), E);
      chk({mem_wr, mem_wb}, {1'b1, 128'h0});
    end
  endtask : t_zero
  task automatic t_check;
    op(BCU_OP_MAKE, 3'h1, 3'h1, E);
    op(BCU_OP_MOV_STORE, 3'h0, 3'h1, E);
    chk(mem_wb, {B, ~E});
    op(BCU_OP_CHK_LO, 3'h1, 3'h1, B - 64'h1);
    fl(4'b0100);
    chk(status, 64'h1);
    op(BCU_OP_CHK_LO, 3'h1, 3'h1, B);
    fl(4'b0000);
    op(BCU_OP_CHK_UP_CPL, 3'h1, 3'h1, (E - 64'h3) + 64'h3);
    fl(4'b0000);
    op(BCU_OP_CHK_UP_CPL, 3'h1, 3'h1, E + 64'h1);
    fl(4'b0100);
    op(BCU_OP_CHK_UP_PLAIN, 3'h1, 3'h1, ~E);
    fl(4'b0000);
    op(BCU_OP_CHK_UP_PLAIN, 3'h1, 3'h1, ~E + 64'h1);
    fl(4'b0100);
    op(BCU_OP_CHK_UP_CPL, 3'h2, 3'h2, 64'hFFFFFFFFFFFFFFFF);
    fl(4'b0000);
    mode_64 = 1'b0;
    op(BCU_OP_CHK_UP_CPL, 3'h1, 3'h1, 64'h00000001000010FF);
    fl(4'b0000);
    mode_64 = 1'b1;
  endtask : t_check
  task automatic t_move;
    op(BCU_OP_MOV_LOAD, 3'h3, 3'h3, E);
    mem = 1'b0;
    op(BCU_OP_MOV_LOAD, 3'h0, 3'h3, E);
    op(BCU_OP_MOV_LOAD, 3'h4, 3'h0, E);
    fl(4'b0010);
    mem = 1'b1;
    op(BCU_OP_MOV_STORE, 3'h0, 3'h0, E);
    chk({mem_wr, mem_wb}, {1'b1, mem_bounds});
  endtask : t_move
  task automatic t_trans;
    p66 = 1'b0;
    op(BCU_OP_TLOAD, 3'h2, 3'h2, E);
    fl(4'b0010);
    p66 = 1'b1;
    op(BCU_OP_TLOAD, 3'h2, 3'h2, E);
    chk(bound_rd, entry.bounds);
    op(BCU_OP_TSTORE, 3'h2, 3'h2, E);
    chk({entry_wr, entry_wd, lookup}, {1'b1, entry.bounds, P, B});
  endtask : t_trans
  task automatic t_init;
    @(negedge clk_sys_i);
    init_i = 1'b1;
    @(negedge clk_sys_i);
    init_i = 1'b0;
    op(BCU_OP_CFG_WR, 3'h0, 3'h0, E);
    op(BCU_OP_MOV_STORE, 3'h0, 3'h2, E);
    chk({mem_wr, mem_wb}, {1'b1, 128'h0});
  endtask : t_init
  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (10) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    t_cfg();
    t_zero();
    t_check();
    t_move();
    t_trans();
    t_init();
    tally_and_finish();
  end
endmodule : tb_top
